/* File: acc_consts.vh */
// constants for the analog compare control block
// assumes inclusion by bare name from the design files
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_ADDR_W        4
`define ACC_OFS_CSR       4'h0
`define ACC_OFS_IRQ_STAT  4'h1
`define ACC_OFS_IRQ_MASK  4'h2
`define ACC_BIT_EN        7
`define ACC_BIT_REFSEL    6
`define ACC_BIT_FLAG      5
`define ACC_BIT_IE        4
`define ACC_BIT_OUT       3
`define ACC_BIT_PINEN     2
`define ACC_MODE_HI       1
`define ACC_MODE_LO       0
`define ACC_MODE_FALL0    2'h0
`define ACC_MODE_RISE     2'h1
`define ACC_MODE_FALL2    2'h2
`define ACC_MODE_BOTH     2'h3
`define ACC_CSR_RST       8'h00
`define ACC_MASK_RST      8'h00
`define ACC_STAT_RISE     0
`define ACC_STAT_FALL     1
`endif

/* File: acc_sync.v */
// two-flop synchroniser for one level crossing into the bus clock
// assumes the input is asynchronous to clock
`timescale 1ns/10ps
module acc_sync (
   input  wire clock,
   input  wire rst_n,
   input  wire clr,
   input  wire din,
   output reg  dout
);
   reg meta_q;

   // first flop feeds only the second; clr forces both low
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else if (clr) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule // acc_sync

/* File: acc_top.v */
// analog compare control: register file, edge detect, flag and interrupt
// assumes an analog core whose raw compare result arrives asynchronously
//
// What this block does
// R01 - comparator runs only while enable bit 7 is one
// R02 - bit 6 picks external pin (0) or bandgap (1) as non-inverting input
// R03 - matching output transition sets sticky event flag bit 5
// R04 - writing one to bit 5 clears flag; zero leaves it
// R05 - interrupt request while bit 4 set and flag set
// R06 - bit 3 reads live comparator output without side effects
// R07 - output bit resets to zero and reads zero while disabled
// R08 - bit 2 puts comparator output on the output pin
// R09 - mode 00/10 falling, 01 rising, 11 either edge
// R10 - output high when non-inverting input exceeds inverting input
// R11 - enabled comparator keeps running during wait
// R12 - in light stop, detection, flag, pin and wake continue
// R13 - deep stop powers down; wake returns registers to reset
// R14 - output synchronised, edges from two consecutive samples
`timescale 1ns/10ps
`include "acc_consts.vh"
module acc_top (
   input  wire                   clock,
   input  wire                   rst_n,
   input  wire [`ACC_ADDR_W-1:0] addr,
   input  wire [7:0]             wdata,
   input  wire                   wr_en,
   input  wire                   rd_en,
   output reg  [7:0]             rdata,
   input  wire                   compare_raw,
   input  wire                   deep_stop,
   output reg                    analog_comparator_enable,
   output reg                    reference_source_select,
   output reg                    comparator_out_pin,
   output reg                    compare_irq,
   output reg                    wake_req,
   output reg                    irq
);
   reg        comparator_enable_q;
   reg        reference_source_select_q;
   reg        compare_event_flag_q;
   reg        compare_irq_enable_q;
   reg        output_pin_enable_q;
   reg  [1:0] event_mode_select_q;
   reg        prev_q;
   reg  [1:0] stat_q;
   reg  [7:0] mask_q;
   wire       out_sync;
   wire       rise;
   wire       fall;
   reg        hit;
   wire       csr_wr;
   wire [7:0] csr_val;
   wire       flag_d;
   wire [1:0] stat_d;

   // raw result is high when non-inverting exceeds inverting input; R10
   // sync flops held clear while disabled so the value reads zero; R07
   acc_sync u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .clr   (~comparator_enable_q | deep_stop),
      .din   (compare_raw),
      .dout  (out_sync)
   );

   // edges from two consecutive synchronised samples
   assign rise = out_sync & ~prev_q; // R14
   assign fall = ~out_sync & prev_q; // R14

   // mode decode; both falling codes kept distinct for clarity
   always @* begin
      case (event_mode_select_q)
         `ACC_MODE_FALL0: hit = fall; // R09
         `ACC_MODE_RISE:  hit = rise; // R09
         `ACC_MODE_FALL2: hit = fall; // R09
         `ACC_MODE_BOTH:  hit = rise | fall; // R09
         default:         hit = 1'b0;
      endcase
   end

   assign csr_wr = wr_en && (addr == `ACC_OFS_CSR);

   // set beats a simultaneous write-one clear, so no event is lost
   assign flag_d = (comparator_enable_q & hit) | // R03
                   (compare_event_flag_q & ~(csr_wr & wdata[`ACC_BIT_FLAG])); // R04

   // aux interrupt status: sticky rise/fall seen, write-one clear
   assign stat_d = ({fall, rise} & {2{comparator_enable_q}}) |
                   (stat_q & ~({2{wr_en && (addr == `ACC_OFS_IRQ_STAT)}} & wdata[1:0]));

   assign csr_val = {comparator_enable_q, reference_source_select_q, compare_event_flag_q,
                     compare_irq_enable_q, out_sync, output_pin_enable_q, event_mode_select_q};

   // control registers; deep stop returns everything to reset values
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         comparator_enable_q       <= 1'b0;
         reference_source_select_q <= 1'b0;
         compare_event_flag_q      <= 1'b0;
         compare_irq_enable_q      <= 1'b0;
         output_pin_enable_q       <= 1'b0;
         event_mode_select_q       <= 2'h0;
         prev_q                    <= 1'b0;
         stat_q                    <= 2'h0;
         mask_q                    <= `ACC_MASK_RST;
      end else if (deep_stop) begin
         comparator_enable_q       <= 1'b0; // R13
         reference_source_select_q <= 1'b0;
         compare_event_flag_q      <= 1'b0;
         compare_irq_enable_q      <= 1'b0;
         output_pin_enable_q       <= 1'b0;
         event_mode_select_q       <= 2'h0;
         prev_q                    <= 1'b0;
         stat_q                    <= 2'h0;
         mask_q                    <= `ACC_MASK_RST;
      end else begin
         prev_q               <= out_sync; // R14
         compare_event_flag_q <= flag_d;
         stat_q               <= stat_d;
         if (csr_wr) begin
            comparator_enable_q       <= wdata[`ACC_BIT_EN]; // R01
            reference_source_select_q <= wdata[`ACC_BIT_REFSEL]; // R02
            compare_irq_enable_q      <= wdata[`ACC_BIT_IE];
            output_pin_enable_q       <= wdata[`ACC_BIT_PINEN];
            event_mode_select_q       <= wdata[`ACC_MODE_HI:`ACC_MODE_LO];
         end
         if (wr_en && (addr == `ACC_OFS_IRQ_MASK))
            mask_q <= {6'h00, wdata[1:0]};
      end
   end

   // outputs straight from flops; only deep stop gates them, not wait or light stop, so the block runs on; R11 R12
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         analog_comparator_enable <= 1'b0;
         reference_source_select  <= 1'b0;
         comparator_out_pin       <= 1'b0;
         compare_irq              <= 1'b0;
         wake_req                 <= 1'b0;
         irq                      <= 1'b0;
         rdata                    <= 8'h00;
      end else begin
         analog_comparator_enable <= comparator_enable_q & ~deep_stop; // R01
         reference_source_select  <= reference_source_select_q; // R02
         comparator_out_pin       <= output_pin_enable_q & out_sync & ~deep_stop; // R08 R13
         compare_irq              <= compare_irq_enable_q & flag_d & ~deep_stop; // R05
         wake_req                 <= compare_irq_enable_q & flag_d & ~deep_stop; // R12
         irq                      <= |(stat_d & mask_q[1:0]) & ~deep_stop;
         // reads have no side effect on any state
         if (rd_en) begin
            case (addr)
               `ACC_OFS_CSR:      rdata <= csr_val; // R06
               `ACC_OFS_IRQ_STAT: rdata <= {6'h00, stat_q};
               `ACC_OFS_IRQ_MASK: rdata <= mask_q;
               default:           rdata <= 8'h00;
            endcase
         end else begin
            rdata <= 8'h00;
         end
      end
   end
endmodule // acc_top

/* File: acc_top_props.sv */
// checker for the compare control block, port relations only
// assumes the constants header and the acc_top port list
`timescale 1ns/10ps
`include "acc_consts.vh"
module acc_top_props (
   input wire                   clock, rst_n,
   input wire [`ACC_ADDR_W-1:0] addr,
   input wire [7:0]             wdata, rdata,
   input wire                   wr_en, rd_en, compare_raw, deep_stop,
   input wire                   analog_comparator_enable, reference_source_select,
   input wire                   comparator_out_pin, compare_irq, wake_req, irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // wake request mirrors the interrupt
   wake_match_a: assert property (wake_req == compare_irq) else $error("wake differs from irq");
   // read data only right after a read strobe
   rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("stray read data");
   unmapped_read_a: assert property (rd_en && addr > 4'h2 |=> rdata == 8'h00) else $error("unmapped read");
   // power-down forces enable, interrupt and pin outputs back to reset levels
   deep_reset_a: assert property (
      deep_stop |=> !analog_comparator_enable && !compare_irq && !comparator_out_pin && !irq)
      else $error("deep stop kept state");
   // sticky sources only drop on a write or power-down; a cleared enable or mask lands a cycle later
   flag_hold_a: assert property (
      $fell(compare_irq) |-> $past(wr_en) || $past(wr_en, 2) || $past(deep_stop))
      else $error("flag dropped alone");
   aux_hold_a: assert property (
      $fell(irq) |-> $past(wr_en) || $past(wr_en, 2) || $past(deep_stop))
      else $error("irq dropped alone");
   cfg_hold_a: assert property (
      $changed(reference_source_select) |-> $past(wr_en) || $past(wr_en, 2)
      || $past(deep_stop) || $past(deep_stop, 2)) else $error("source select moved");
   // pin level must come from a high comparator result
   pin_source_a: assert property (
      $rose(comparator_out_pin) |-> $past(compare_raw, 2) || $past(compare_raw, 3) || $past(compare_raw, 4))
      else $error("pin rose without input");
endmodule // acc_top_props
bind acc_top acc_top_props chk_u (.*);

/* File: acc_analog_model.sv */
// behavioural analog core facing the compare control block
// assumes integer stand-ins for voltages; output moves on falling edges
`timescale 1ns/10ps
module acc_analog_model #(
   parameter int BANDGAP = 7  // stand-in reference level
) (
   input wire  clock, en, refsel,
   input int   vplus, vminus,
   output logic compare_raw
);
   // held low while off, so no stale level leaks into the syncs
   always @(negedge clock)
      compare_raw <= en && ((refsel ? BANDGAP : vplus) > vminus);
endmodule // acc_analog_model

/* File: acc_top_tb_top.sv */
// testbench: register-level sequences for the compare control block
// assumes acc_top, its checker and the analog model compiled first
`timescale 1ns/10ps
module acc_top_tb_top;
   logic       clock = 0, rst_n = 0, wr_en = 0, rd_en = 0, deep_stop = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, m;
   logic       compare_raw, analog_comparator_enable, reference_source_select;
   logic       comparator_out_pin, compare_irq, wake_req, irq;
   int         vp = 0, vm = 5, failures = 0, check_count = 0;
   initial forever #2 clock = ~clock;
   acc_top dut_u (.*);
   acc_analog_model model_u (.clock(clock), .en(analog_comparator_enable), .refsel(reference_source_select),
                             .vplus(vp), .vminus(vm), .compare_raw(compare_raw));
   task chk(input logic [7:0] got, exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle strobes, released on the following edge
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a; rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // sync chain plus edge detect needs a few cycles
   task settle;
      repeat (8) @(posedge clock);
   endtask
   task end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000 failures++;
      end_sim;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'h2, 8'h00);
      vp <= 9;
      wr(4'h0, 8'h94);
      settle;
      rd(4'h0, 8'h9C);
      chk(comparator_out_pin, 8'h01);
      chk(analog_comparator_enable, 8'h01);
      wr(4'h0, 8'h90);
      settle;
      chk(comparator_out_pin, 8'h00);
      vp <= 0;
      settle;
      rd(4'h0, 8'hB0);
      chk(wake_req, 8'h01);
      chk(compare_irq, 8'h01);
      wr(4'h0, 8'h90);
      rd(4'h0, 8'hB0);
      wr(4'h0, 8'hB0);
      rd(4'h0, 8'h90);
      wr(4'h1, 8'h03);
      wr(4'h2, 8'h03);
      // every mode code against a rise then a fall, interrupt off
      for (m = 0; m < 4; m++) begin
         wr(4'h0, 8'hA0 | m);
         vp <= 9;
         settle;
         rd(4'h0, 8'h88 | m | (m[0] << 5));
         chk(compare_irq, 8'h00);
         wr(4'h0, 8'hA0 | m);
         vp <= 0;
         settle;
         rd(4'h0, 8'h80 | m | ((m != 1) << 5));
      end
      chk(irq, 8'h01);
      wr(4'h1, 8'h01);
      rd(4'h1, 8'h02);
      wr(4'h1, 8'h02);
      // irq drops at the clearing edge itself, so look half a cycle later
      @(negedge clock);
      chk(irq, 8'h00);
      wr(4'h2, 8'h00);
      vp <= 9;
      settle;
      rd(4'h1, 8'h01);
      chk(irq, 8'h00);
      wr(4'h0, 8'hE0);
      // let the source switch land first, else the pin drop shows as a false fall
      settle;
      vp <= 0;
      settle;
      rd(4'h0, 8'hC8);
      chk(reference_source_select, 8'h01);
      vm <= 9;
      settle;
      rd(4'h0, 8'hE0);
      wr(4'h0, 8'h20);
      vm <= 0;
      settle;
      rd(4'h0, 8'h00);
      wr(4'h0, 8'hD4);
      settle;
      chk(comparator_out_pin, 8'h01);
      deep_stop <= 1'b1;
      repeat (3) @(posedge clock);
      chk(comparator_out_pin, 8'h00);
      chk(analog_comparator_enable, 8'h00);
      deep_stop <= 1'b0;
      rd(4'h0, 8'h00);
      wr(4'h5, 8'hFF);
      rd(4'h5, 8'h00);
      end_sim;
   end
endmodule // acc_top_tb_top
